// ### clp_pkg.sv
// Constants, register map and types shared by the limit and preset compare block.
package clp_pkg;
  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_HI = 8'h04;
  localparam logic [7:0] OFF_LO = 8'h08;
  localparam logic [7:0] OFF_ON = 8'h0C;
  localparam logic [7:0] OFF_OFF = 8'h10;
  localparam logic [7:0] OFF_HOME = 8'h14;
  localparam logic [7:0] OFF_PRE1 = 8'h18;
  localparam logic [7:0] OFF_PRE2 = 8'h1C;
  localparam logic [7:0] OFF_ACC = 8'h20;
  localparam logic [7:0] OFF_STATUS = 8'h24;
  // Control field positions.
  localparam int CTRL_SINGLE = 0;
  localparam int CTRL_TYPE_LSB = 1;
  localparam int CTRL_EXT = 3;
  localparam int CTRL_A32 = 4;
  localparam int CTRL_FAIL_LSB = 5;
  localparam int CTRL_HOME = 7;
  localparam int CTRL_W = 8;
  localparam logic [1:0] TYPE_A = 2'h0;
  localparam logic [1:0] TYPE_C = 2'h2;
  localparam logic [1:0] FAIL_OFF = 2'h1;
  localparam logic [1:0] FAIL_HOLD = 2'h2;
  // Status field positions.
  localparam int ST_LIMIT_ERR = 0;
  localparam int ST_HOME_ERR = 1;
  // Reset values.
  localparam logic [CTRL_W-1:0] CTRL_RST = 8'h00;
  localparam logic signed [31:0] HI_RST = 32'sh0000_7FFF;
  localparam logic signed [31:0] LO_RST = 32'sh0000_0000;
  localparam logic signed [31:0] ON_RST = 32'sh0000_7FFF;
  localparam logic signed [31:0] OFF_RST = 32'sh0000_0000;
  localparam logic signed [31:0] HOME_RST = 32'sh0000_0000;
  localparam logic signed [31:0] PRE_RST = 32'sh0000_0000;
  // Timing.
  localparam int CLK_HZ = 50_000_000;
  localparam int CMP_PERIOD_US = 500;
  localparam int CMP_PERIOD_CYC = CLK_HZ / 1_000_000 * CMP_PERIOD_US;
  localparam int HOST_TIMEOUT_MS = 100;
  localparam int HOST_TIMEOUT_CYC = CLK_HZ / 1000 * HOST_TIMEOUT_MS;
  typedef enum logic [2:0] {
    HM_IDLE = 3'h1,
    HM_WAIT = 3'h2,
    HM_DONE = 3'h4
  } clp_home_t;
endpackage

// ### clp_pin_sync.sv
// Two-stage synchroniser with rising-edge pulse for one field input.
`timescale 1ns/1ns
module clp_pin_sync (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_ce,
  input wire logic i_pin,
  output logic o_level,
  output logic o_rise
);
  logic [2:0] sh_q;
  logic [2:0] sh_d;

  always_comb begin
    sh_d = {sh_q[1:0], i_pin};
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sh_q <= 3'h0;
    end else if (i_ce) begin
      sh_q <= sh_d;
    end
  end

  // Only the second and third stages are looked at, never the first.
  assign o_level = sh_q[1];
  assign o_rise = sh_q[1] & ~sh_q[2];
endmodule

// ### clp_top.sv
// Counter limits, preload, home sequence, preset compare and host-loss output handling.
`timescale 1ns/1ns
// Behaviour
// (RQ1) Hold upper and lower limits; upper always strictly above lower.
// (RQ2) Accepted limits that exclude the accumulator force it to the new lower limit.
// (RQ3) Reject pairs with upper not above lower, keep old ones, flag limit error.
// (RQ4) Limits and preloads are signed 16-bit for type A, 32-bit otherwise.
// (RQ5) ON below OFF: output on while ON <= accumulator <= OFF.
// (RQ6) Between points take the lower point's state, outside the higher's.
// (RQ7) One point in range: the limit stands in as the other point.
// (RQ8) No point in range: output fixed at the higher point's state.
// (RQ9) Equal points out of range: output always off.
// (RQ10) Equal points in range: output on only at that value.
// (RQ11) Compare accumulator against points once every half millisecond.
// (RQ12) Host keeps ON and OFF apart by counts arriving in one period.
// (RQ13) Type C: first marker while home command and switch active loads home value.
// (RQ14) After home load ignore markers until the command is withdrawn and reissued.
// (RQ15) Command withdrawn before the marker raises a home error.
// (RQ16) Preload input loads its value; type C has two preload values.
// (RQ17) Preload above upper counts down; idle or up period triggers overflow handling.
// (RQ18) Preload below lower holds, counts up; a down count triggers underflow.
// (RQ19) On host loss: normal, force output off, or freeze output.
// (RQ20) Host-loss response lasts until the host returns or reset.
// (RQ21) Host moves upper first when shifting up, lower first when down.
// (RQ22) Extended mode lets type A pick 32-bit; other types are 32-bit.
// (RQ23) Continuous mode wraps past a limit to the opposite limit.
// (RQ24) Single-shot stops at a limit; opposite counts move it back off.
// (RQ25) Host loss after a refresh timeout; cleared by the next host access.
module clp_top #(
  parameter int CMP_PERIOD_CYC_P = clp_pkg::CMP_PERIOD_CYC,
  parameter int HOST_TIMEOUT_CYC_P = clp_pkg::HOST_TIMEOUT_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_cnt_up,
  input wire logic i_cnt_dn,
  input wire logic i_preload1,
  input wire logic i_preload2,
  input wire logic i_marker,
  input wire logic i_home_sw,
  output logic o_preset_out,
  output logic o_host_lost,
  output logic o_limit_err,
  output logic o_home_err
);
  import clp_pkg::*;

  localparam int TW = $clog2(CMP_PERIOD_CYC_P);
  localparam int WW = $clog2(HOST_TIMEOUT_CYC_P);

  // Reset release through two flops.
  logic rst_s1_q;
  logic rst_n;
  always_ff @(posedge i_mclk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_s1_q <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n <= rst_s1_q;
    end
  end

  // Field inputs: 0 up, 1 down, 2 preload1, 3 preload2, 4 marker, 5 home switch.
  logic [5:0] pins;
  logic [5:0] lvl;
  logic [5:0] rise;
  assign pins = {i_home_sw, i_marker, i_preload2, i_preload1, i_cnt_dn, i_cnt_up};
  for (genvar g = 0; g < 6; g++) begin : g_pin
    clp_pin_sync u_sync (
      .i_clk(i_mclk),
      .i_rst_n(rst_n),
      .i_ce(i_ce),
      .i_pin(pins[g]),
      .o_level(lvl[g]),
      .o_rise(rise[g])
    );
  end

  function automatic logic signed [31:0] fit(input logic [31:0] v, input logic n16);
    fit = n16 ? {{16{v[15]}}, v[15:0]} : v;
  endfunction

  logic [CTRL_W-1:0] ctrl_q, ctrl_d;
  logic signed [31:0] hi_q, hi_d, lo_q, lo_d, on_q, on_d, off_q, off_d;
  logic signed [31:0] home_q, home_d, pre1_q, pre1_d, pre2_q, pre2_d;
  logic signed [31:0] acc_q, acc_d;
  logic limit_err_q, limit_err_d, home_err_q, home_err_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic saw_dn_q, saw_dn_d, cmp_q, cmp_d, out_q, out_d;
  logic host_lost_q, host_lost_d;
  logic [TW-1:0] tk_q, tk_d;
  logic [WW-1:0] wd_q, wd_d;
  clp_home_t hm_q, hm_d;

  logic apb_fire, wr_en, is16, single, type_c, home_cmd, home_load, tick;
  logic signed [31:0] cand_hi, cand_lo;
  logic lim_req, lim_ok, lim_bad, cnt_path, up_only, dn_only;
  logic [31:0] rdv;
  logic hit;
  logic [1:0] fail_mode;

  assign apb_fire = i_psel & i_penable & pready_q;
  assign wr_en = apb_fire & i_pwrite;
  assign single = ctrl_q[CTRL_SINGLE];
  assign type_c = ctrl_q[CTRL_TYPE_LSB +: 2] == TYPE_C;
  assign is16 = (ctrl_q[CTRL_TYPE_LSB +: 2] == TYPE_A) & ~(ctrl_q[CTRL_EXT] & ctrl_q[CTRL_A32]); // RQ4 RQ22
  assign home_cmd = ctrl_q[CTRL_HOME] & type_c;
  assign fail_mode = ctrl_q[CTRL_FAIL_LSB +: 2];
  assign up_only = rise[0] & ~rise[1];
  assign dn_only = rise[1] & ~rise[0];

  // APB slave: one wait state, read data sampled in the first access cycle.
  always_comb begin
    rdv = 32'h0000_0000;
    hit = 1'b1;
    if (i_paddr == OFF_CTRL) begin
      rdv = {24'h00_0000, ctrl_q};
    end else if (i_paddr == OFF_HI) begin
      rdv = hi_q;
    end else if (i_paddr == OFF_LO) begin
      rdv = lo_q;
    end else if (i_paddr == OFF_ON) begin
      rdv = on_q;
    end else if (i_paddr == OFF_OFF) begin
      rdv = off_q;
    end else if (i_paddr == OFF_HOME) begin
      rdv = home_q;
    end else if (i_paddr == OFF_PRE1) begin
      rdv = pre1_q;
    end else if (i_paddr == OFF_PRE2) begin
      rdv = pre2_q;
    end else if (i_paddr == OFF_ACC) begin
      rdv = acc_q;
    end else if (i_paddr == OFF_STATUS) begin
      rdv = {25'h000_0000, is16, out_q, cmp_q, host_lost_q, hm_q == HM_DONE, home_err_q, limit_err_q};
    end else begin
      hit = 1'b0;
    end
    pready_d = i_psel & i_penable & ~pready_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    if (pready_d) begin
      prdata_d = rdv;
      pslverr_d = ~hit;
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else if (i_ce) begin
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Configuration and limits; limits are tried as a pair with the other stored limit.
  always_comb begin
    ctrl_d = ctrl_q;
    on_d = on_q;
    off_d = off_q;
    home_d = home_q;
    pre1_d = pre1_q;
    pre2_d = pre2_q;
    cand_hi = hi_q;
    cand_lo = lo_q;
    lim_req = 1'b0;
    if (wr_en && i_paddr == OFF_CTRL) begin
      ctrl_d = i_pwdata[CTRL_W-1:0];
    end
    if (wr_en && i_paddr == OFF_ON) begin
      on_d = fit(i_pwdata, is16);
    end
    if (wr_en && i_paddr == OFF_OFF) begin
      off_d = fit(i_pwdata, is16);
    end
    if (wr_en && i_paddr == OFF_HOME) begin
      home_d = i_pwdata;
    end
    if (wr_en && i_paddr == OFF_PRE1) begin
      pre1_d = fit(i_pwdata, is16); // RQ4
    end
    if (wr_en && i_paddr == OFF_PRE2) begin
      pre2_d = i_pwdata;
    end
    if (wr_en && i_paddr == OFF_HI) begin
      cand_hi = fit(i_pwdata, is16);
      lim_req = 1'b1;
    end else if (wr_en && i_paddr == OFF_LO) begin
      cand_lo = fit(i_pwdata, is16);
      lim_req = 1'b1;
    end
    lim_ok = lim_req & (cand_hi > cand_lo); // RQ1
    lim_bad = lim_req & ~lim_ok; // RQ3
    hi_d = lim_ok ? cand_hi : hi_q;
    lo_d = lim_ok ? cand_lo : lo_q;
    // A new error wins over a clear written in the same cycle.
    limit_err_d = lim_bad | (limit_err_q & ~(wr_en && i_paddr == OFF_STATUS && i_pwdata[ST_LIMIT_ERR]));
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CTRL_RST;
      hi_q <= HI_RST;
      lo_q <= LO_RST;
      on_q <= ON_RST;
      off_q <= OFF_RST;
      home_q <= HOME_RST;
      pre1_q <= PRE_RST;
      pre2_q <= PRE_RST;
      limit_err_q <= 1'b0;
    end else if (i_ce) begin
      ctrl_q <= ctrl_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
      on_q <= on_d;
      off_q <= off_d;
      home_q <= home_d;
      pre1_q <= pre1_d;
      pre2_q <= pre2_d;
      limit_err_q <= limit_err_d;
    end
  end

  // Home sequence for the differential type.
  always_comb begin
    hm_d = hm_q;
    home_load = 1'b0;
    home_err_d = home_err_q & ~(wr_en && i_paddr == OFF_STATUS && i_pwdata[ST_HOME_ERR]);
    case (hm_q)
      HM_IDLE: begin
        if (home_cmd) begin
          hm_d = HM_WAIT;
        end
      end
      HM_WAIT: begin
        if (!home_cmd) begin
          hm_d = HM_IDLE;
          home_err_d = 1'b1; // RQ15
        end else if (rise[4] && lvl[5]) begin
          hm_d = HM_DONE;
          home_load = 1'b1; // RQ13
        end
      end
      HM_DONE: begin
        if (!home_cmd) begin
          hm_d = HM_IDLE; // RQ14
        end
      end
      default: begin
        hm_d = HM_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      hm_q <= HM_IDLE;
      home_err_q <= 1'b0;
    end else if (i_ce) begin
      hm_q <= hm_d;
      home_err_q <= home_err_d;
    end
  end

  // Compare period timebase.
  always_comb begin
    tick = tk_q == TW'(CMP_PERIOD_CYC_P - 1);
    tk_d = tick ? '0 : tk_q + TW'(1); // RQ11
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      tk_q <= '0;
    end else if (i_ce) begin
      tk_q <= tk_d;
    end
  end

  // Accumulator; home load beats limit change, host load, preload and counting.
  always_comb begin
    acc_d = acc_q;
    cnt_path = 1'b0;
    saw_dn_d = tick ? 1'b0 : (saw_dn_q | rise[1]);
    if (home_load) begin
      acc_d = home_q; // RQ13
    end else if (lim_ok && (acc_q > cand_hi || acc_q < cand_lo)) begin
      acc_d = cand_lo; // RQ2
    end else if (wr_en && i_paddr == OFF_ACC) begin
      acc_d = fit(i_pwdata, is16);
    end else if (rise[2]) begin
      acc_d = pre1_q; // RQ16
    end else if (rise[3] && type_c) begin
      acc_d = pre2_q; // RQ16
    end else begin
      cnt_path = 1'b1;
      if (up_only) begin
        if (acc_q >= hi_q) begin
          acc_d = single ? hi_q : lo_q; // RQ23 RQ24 RQ17
        end else begin
          acc_d = acc_q + 32'sh0000_0001; // RQ18
        end
      end else if (dn_only) begin
        if (acc_q > hi_q) begin
          acc_d = acc_q - 32'sh0000_0001; // RQ17
        end else if (acc_q <= lo_q) begin
          acc_d = single ? lo_q : hi_q; // RQ23 RQ24 RQ18
        end else begin
          acc_d = acc_q - 32'sh0000_0001;
        end
      end else if (tick && acc_q > hi_q && !saw_dn_q) begin
        acc_d = single ? hi_q : lo_q; // RQ17
      end
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= PRE_RST;
      saw_dn_q <= 1'b0;
    end else if (i_ce) begin
      acc_q <= acc_d;
      saw_dn_q <= saw_dn_d;
    end
  end

  // Preset compare; a point outside the range is replaced by the limit beyond it.
  logic on_in, off_in, low_is_on, cmp_raw;
  logic signed [31:0] eff_on, eff_off, pt_lo, pt_hi;
  always_comb begin
    on_in = (on_q >= lo_q) && (on_q <= hi_q);
    off_in = (off_q >= lo_q) && (off_q <= hi_q);
    eff_on = on_in ? on_q : ((on_q > hi_q) ? hi_q : lo_q); // RQ7
    eff_off = off_in ? off_q : ((off_q > hi_q) ? hi_q : lo_q); // RQ7
    low_is_on = eff_on <= eff_off;
    pt_lo = low_is_on ? eff_on : eff_off;
    pt_hi = low_is_on ? eff_off : eff_on;
    if (on_q == off_q) begin
      cmp_raw = on_in && (acc_q == on_q); // RQ9 RQ10
    end else if (!on_in && !off_in) begin
      cmp_raw = on_q > off_q; // RQ8
    end else if (acc_q >= pt_lo && acc_q <= pt_hi) begin
      cmp_raw = low_is_on; // RQ5 RQ6
    end else begin
      cmp_raw = ~low_is_on; // RQ5 RQ6
    end
    cmp_d = tick ? cmp_raw : cmp_q; // RQ11
  end

  // Host watchdog and output fail response. Any completed access counts as a refresh.
  always_comb begin
    wd_d = wd_q;
    host_lost_d = host_lost_q;
    if (apb_fire) begin
      wd_d = '0;
      host_lost_d = 1'b0; // RQ25 RQ20
    end else if (wd_q == WW'(HOST_TIMEOUT_CYC_P - 1)) begin
      host_lost_d = 1'b1; // RQ25
    end else begin
      wd_d = wd_q + WW'(1);
    end
    out_d = cmp_q;
    if (host_lost_q && fail_mode == FAIL_OFF) begin
      out_d = 1'b0; // RQ19
    end else if (host_lost_q && fail_mode == FAIL_HOLD) begin
      out_d = out_q; // RQ19
    end
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmp_q <= 1'b0;
      out_q <= 1'b0;
      wd_q <= '0;
      host_lost_q <= 1'b0;
    end else if (i_ce) begin
      cmp_q <= cmp_d;
      out_q <= out_d;
      wd_q <= wd_d;
      host_lost_q <= host_lost_d;
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = pready_q;
  assign o_pslverr = pslverr_q;
  assign o_preset_out = out_q;
  assign o_host_lost = host_lost_q;
  assign o_limit_err = limit_err_q;
  assign o_home_err = home_err_q;

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!rst_n);

  sequence s_home_armed;
    i_ce && hm_q == HM_WAIT && home_cmd && rise[4] && lvl[5];
  endsequence
  sequence s_cmd_dropped;
    i_ce && hm_q == HM_WAIT && !home_cmd;
  endsequence

  chk_limit_order: assert property (hi_q > lo_q) else $error("upper limit not above lower"); // RQ1
  chk_limit_reject: assert property (i_ce && lim_bad |=> // RQ3
    hi_q == $past(hi_q) && lo_q == $past(lo_q) && limit_err_q) else $error("bad limits taken");
  chk_acc_forced: assert property (i_ce && lim_ok && !home_load && (acc_q > cand_hi || acc_q < cand_lo) // RQ2
    |=> acc_q == $past(cand_lo)) else $error("accumulator not moved to new lower limit");
  chk_cmp_period: assert property ($changed(cmp_q) |-> $past(tick)) else $error("compare outside period"); // RQ11
  chk_equal_pts: assert property (on_q == off_q |-> cmp_raw == (on_in && acc_q == on_q)) // RQ9
    else $error("equal points compare wrong");
  chk_no_pts: assert property (on_q != off_q && !on_in && !off_in |-> cmp_raw == (on_q > off_q)) // RQ8
    else $error("no point in range compare wrong");
  chk_home_load: assert property (s_home_armed |=> acc_q == $past(home_q) && hm_q == HM_DONE) // RQ13
    else $error("home value not loaded");
  chk_home_ignore: assert property (i_ce && hm_q == HM_DONE && home_cmd |=> hm_q == HM_DONE && !home_load) // RQ14
    else $error("marker taken after home");
  chk_home_error: assert property (s_cmd_dropped |=> home_err_q && hm_q == HM_IDLE) // RQ15
    else $error("home error missing");
  chk_force_off: assert property (i_ce && host_lost_q && fail_mode == FAIL_OFF |=> !out_q) // RQ19
    else $error("output not forced off");
  chk_lost_holds: assert property (i_ce && host_lost_q && !apb_fire |=> host_lost_q) // RQ20
    else $error("host loss cleared without access");
  chk_wrap_up: assert property (i_ce && cnt_path && up_only && !single && acc_q == hi_q // RQ23
    |=> acc_q == $past(lo_q)) else $error("no wrap to lower limit");
endmodule

// ### clp_field.sv
// Field-side model: count, preload and marker pulses plus the home limit switch.
`timescale 1ns/1ns
module clp_field (
  input wire logic i_clk,
  output logic o_up,
  output logic o_dn,
  output logic o_pl1,
  output logic o_pl2,
  output logic o_mark,
  output logic o_sw
);
  logic [4:0] p;
  assign o_up = p[0];
  assign o_dn = p[1];
  assign o_pl1 = p[2];
  assign o_pl2 = p[3];
  assign o_mark = p[4];
  initial begin
    p = 5'h00;
    o_sw = 1'b0;
  end
  // Four cycles high and four low, so the two-flop pin synchroniser sees every edge.
  task automatic pulse(input int i);
    @(posedge i_clk);
    p[i] <= 1'b1;
    repeat (4) @(posedge i_clk);
    p[i] <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
  task automatic set_sw(input logic v);
    @(posedge i_clk);
    o_sw <= v;
  endtask
endmodule

// ### tb.sv
// Self-checking bench for the limit, preload, home and preset compare block.
`timescale 1ns/1ns
module tb;
  import clp_pkg::*;
  localparam int PER = 16;
  localparam int WT = 2 * PER + 4;
  logic clk, rst_b, ce, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic up, dn, pl1, pl2, mark, sw, pout, lost, lerr, herr;
  int error_cnt = 0;
  int samples_checked = 0;
  clp_top #(.CMP_PERIOD_CYC_P(PER), .HOST_TIMEOUT_CYC_P(64)) clp_top_inst (
    .i_mclk(clk), .i_rst_b(rst_b), .i_ce(ce), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_cnt_up(up), .i_cnt_dn(dn), .i_preload1(pl1), .i_preload2(pl2), .i_marker(mark), .i_home_sw(sw),
    .o_preset_out(pout), .o_host_lost(lost), .o_limit_err(lerr), .o_home_err(herr));
  clp_field clp_field_inst (
    .i_clk(clk), .o_up(up), .o_dn(dn), .o_pl1(pl1), .o_pl2(pl2), .o_mark(mark), .o_sw(sw));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic results();
    $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    error_cnt++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic chk32(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) fail($sformatf("value %h expected %h", g, e));
  endtask
  task automatic chk1(input logic g, input logic e);
    samples_checked++;
    if (g !== e) fail($sformatf("flag %b expected %b", g, e));
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // One APB transfer; the request is held until pready is seen high at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
                     output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      fail("no bus answer");
      results();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    chk32(r, x);
  endtask
  task automatic t_reset();
    logic [31:0] r;
    logic e;
    rd(OFF_HI, 32'h0000_7FFF);
    rd(OFF_LO, 32'h0);
    rd(OFF_ON, 32'h0000_7FFF);
    rd(OFF_CTRL, 32'h0);
    apb(1'b0, 8'h40, 32'h0, r, e);
    chk1(e, 1'b1);
    chk32(r, 32'h0);
    $display("t_reset done");
  endtask
  task automatic t_limits();
    wr(OFF_HI, 32'h64);
    wr(OFF_LO, 32'h0000_FFEC);
    rd(OFF_LO, 32'hFFFF_FFEC);
    wr(OFF_ACC, 32'h32);
    // Equal limits are the tightest illegal pair.
    wr(OFF_LO, 32'h64);
    cyc(2);
    chk1(lerr, 1'b1);
    rd(OFF_LO, 32'hFFFF_FFEC);
    rd(OFF_ACC, 32'h32);
    wr(OFF_STATUS, 32'h1);
    cyc(2);
    chk1(lerr, 1'b0);
    wr(OFF_HI, 32'h1E);
    rd(OFF_ACC, 32'hFFFF_FFEC);
    rd(OFF_HI, 32'h1E);
    wr(OFF_HI, 32'h64);
    wr(OFF_LO, 32'h0);
    $display("t_limits done");
  endtask
  task automatic t_count();
    wr(OFF_ACC, 32'h64);
    clp_field_inst.pulse(0);
    rd(OFF_ACC, 32'h0);
    clp_field_inst.pulse(1);
    rd(OFF_ACC, 32'h64);
    wr(OFF_CTRL, 32'h1);
    clp_field_inst.pulse(0);
    rd(OFF_ACC, 32'h64);
    clp_field_inst.pulse(1);
    rd(OFF_ACC, 32'h63);
    wr(OFF_CTRL, 32'h0);
    $display("t_count done");
  endtask
  task automatic t_compare();
    // Columns: ON point, OFF point, accumulator, expected output; limits are 0 and 100.
    int tab[15][4] = '{'{2, 4, 1, 0}, '{2, 4, 2, 1}, '{2, 4, 4, 1}, '{2, 4, 5, 0}, '{4, 2, 3, 0},
      '{4, 2, 2, 0}, '{4, 2, 1, 1}, '{4, 2, 5, 1}, '{5, 150, 7, 1}, '{5, 150, 2, 0},
      '{200, 300, 50, 0}, '{300, 200, 50, 1}, '{200, 200, 50, 0}, '{3, 3, 3, 1}, '{3, 3, 4, 0}};
    foreach (tab[i]) begin
      wr(OFF_ON, tab[i][0]);
      wr(OFF_OFF, tab[i][1]);
      wr(OFF_ACC, tab[i][2]);
      cyc(WT);
      chk1(pout, tab[i][3][0]);
    end
    $display("t_compare done");
  endtask
  task automatic t_preload();
    wr(OFF_PRE1, 32'h96);
    clp_field_inst.pulse(2);
    cyc(WT);
    rd(OFF_ACC, 32'h0);
    wr(OFF_PRE1, 32'h0000_FFFB);
    clp_field_inst.pulse(2);
    cyc(WT);
    rd(OFF_ACC, 32'hFFFF_FFFB);
    clp_field_inst.pulse(0);
    rd(OFF_ACC, 32'hFFFF_FFFC);
    clp_field_inst.pulse(1);
    rd(OFF_ACC, 32'h64);
    wr(OFF_PRE1, 32'hC);
    clp_field_inst.pulse(2);
    rd(OFF_ACC, 32'hC);
    $display("t_preload done");
  endtask
  task automatic t_home();
    wr(OFF_CTRL, 32'h4);
    wr(OFF_PRE2, 32'h22);
    clp_field_inst.pulse(3);
    rd(OFF_ACC, 32'h22);
    wr(OFF_HOME, 32'h4D);
    wr(OFF_CTRL, 32'h84);
    clp_field_inst.pulse(4);
    rd(OFF_ACC, 32'h22);
    clp_field_inst.set_sw(1'b1);
    clp_field_inst.pulse(4);
    rd(OFF_ACC, 32'h4D);
    wr(OFF_ACC, 32'h5);
    clp_field_inst.pulse(4);
    rd(OFF_ACC, 32'h5);
    wr(OFF_CTRL, 32'h4);
    cyc(2);
    chk1(herr, 1'b0);
    wr(OFF_CTRL, 32'h84);
    wr(OFF_CTRL, 32'h4);
    cyc(2);
    chk1(herr, 1'b1);
    wr(OFF_STATUS, 32'h2);
    clp_field_inst.set_sw(1'b0);
    wr(OFF_CTRL, 32'h0);
    $display("t_home done");
  endtask
  task automatic t_fail();
    wr(OFF_ON, 32'h3);
    wr(OFF_OFF, 32'h3);
    wr(OFF_ACC, 32'h3);
    wr(OFF_CTRL, 32'h20);
    cyc(WT);
    chk1(pout, 1'b1);
    cyc(60);
    chk1(lost, 1'b1);
    chk1(pout, 1'b0);
    cyc(40);
    chk1(pout, 1'b0);
    rd(OFF_CTRL, 32'h20);
    cyc(WT);
    chk1(lost, 1'b0);
    chk1(pout, 1'b1);
    wr(OFF_CTRL, 32'h40);
    cyc(80);
    chk1(lost, 1'b1);
    clp_field_inst.pulse(0);
    cyc(WT);
    chk1(pout, 1'b1);
    rd(OFF_ACC, 32'h4);
    cyc(WT);
    chk1(pout, 1'b0);
    $display("t_fail done");
  endtask
  // A count pulse seen only while the enable is low must be lost, then a mid-run reset restores defaults.
  task automatic t_ce();
    wr(OFF_ACC, 32'h7);
    ce <= 1'b0;
    clp_field_inst.pulse(0);
    ce <= 1'b1;
    cyc(4);
    rd(OFF_ACC, 32'h7);
    wr(OFF_CTRL, 32'h18);
    wr(OFF_PRE1, 32'h0001_0005);
    rd(OFF_PRE1, 32'h0001_0005);
    wr(OFF_CTRL, 32'h0);
    wr(OFF_PRE1, 32'h0001_0005);
    rd(OFF_PRE1, 32'h0000_0005);
    rst_b <= 1'b0;
    cyc(5);
    rst_b <= 1'b1;
    cyc(3);
    rd(OFF_PRE1, 32'h0);
    rd(OFF_HOME, 32'h0);
    rd(OFF_HI, 32'h0000_7FFF);
    $display("t_ce done");
  endtask
  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    cyc(3);
    t_reset();
    t_limits();
    t_count();
    t_compare();
    t_preload();
    t_home();
    t_fail();
    t_ce();
    results();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fail("run timeout");
    results();
  end
endmodule
